// >>> hw/rtc_aux_regs.vh
// Register map, field positions, reset values and timing counts of the RTC auxiliary block
`ifndef RTC_AUX_REGS_VH
`define RTC_AUX_REGS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_SECONDS      4'h1
`define ADDR_DAY          4'h4
`define ADDR_CLOCK_LAST   4'h7
`define ADDR_RATE_TRIM    4'h8
`define ADDR_TIMEOUT      4'h9
`define ADDR_AL_MONTH     4'ha
`define ADDR_AL_DATE      4'hb
`define ADDR_AL_HOUR      4'hc
`define ADDR_AL_MIN       4'hd
`define ADDR_AL_SEC       4'he
`define ADDR_EVENT_FLAGS  4'hf
`define AL_REG_COUNT      5

// ****************************************************************
// Field positions
// ****************************************************************
`define HALT_BIT          7
`define RATE_SEL_HI       7
`define RATE_SEL_LO       4
`define TRIM_OUT_BIT      7
`define TRIM_FT_BIT       6
`define TRIM_SIGN_BIT     5
`define TRIM_MAG_HI       4
`define AFE_BIT           7
`define WAVE_PIN_ENABLE_BIT          6
`define TONE_EN_BIT       5
`define REPEAT_BIT        7
`define REPEAT5_BIT       6
`define WD_RES_HI_BIT     7
`define WD_MULT_HI        6
`define WD_MULT_LO        2
`define WD_RES_LO_HI      1

// ****************************************************************
// Reset values
// ****************************************************************
`define RATE_TRIM_RST     8'h00
`define TIMEOUT_RST       8'h00
`define AL_MONTH_RST      8'h60
`define AL_OTHER_RST      8'h00
`define RATE_SEL_RST      4'h1

// ****************************************************************
// Repeat modes, ordered fifth bit down to first
// ****************************************************************
`define RPT_EVERY_SEC     5'h1f
`define RPT_EVERY_MIN     5'h1e
`define RPT_EVERY_HOUR    5'h1c
`define RPT_EVERY_DAY     5'h18
`define RPT_EVERY_MONTH   5'h10
`define RPT_EVERY_YEAR    5'h00

// ****************************************************************
// Timing
// ****************************************************************
`define SYS_CLK_KHZ       20000
`define OSC_PER_SEC       16'h8000
`define CAL_SHORTEN       16'h0080
`define CAL_LENGTHEN      16'h0100
`define SEC_PER_MIN       6'h3c
`define CAL_ELIGIBLE_MIN  6'h3e
`define WD_TICK_OSC       11'h7ff
`define WD_UNIT_16TH      10'h001
`define WD_UNIT_QUARTER   10'h004
`define WD_UNIT_SEC       10'h010
`define WD_UNIT_4SEC      10'h040
`define WD_UNIT_MIN       10'h3c0
`define WD_RES_MAX        3'h4
`define WAVE_512_BIT      5
`define REC_PULSE_MS      200
`define REC_PULSE_CYC     (`REC_PULSE_MS * `SYS_CLK_KHZ)

`endif

// >>> hw/alarm_match.v
// Alarm comparator: repeat-mode decode and field compare
`timescale 1ns/1ps
`include "rtc_aux_regs.vh"

module alarm_match (
  // Repeat bits, fifth down to first
  input  wire [4:0] alarm_repeat_bits,
  // Alarm settings, repeat bits stripped
  input  wire [4:0] al_month,
  input  wire [5:0] al_date,
  input  wire [5:0] al_hour,
  input  wire [6:0] al_min,
  input  wire [6:0] al_sec,
  // Running time
  input  wire [4:0] cur_month,
  input  wire [5:0] cur_date,
  input  wire [5:0] cur_hour,
  input  wire [6:0] cur_min,
  input  wire [6:0] cur_sec,
  // Result
  output reg        match
);

  wire eq_sec;
  wire eq_min;
  wire eq_hour;
  wire eq_date;
  wire eq_month;

  assign eq_sec   = (al_sec == cur_sec);
  assign eq_min   = (al_min == cur_min);
  assign eq_hour  = (al_hour == cur_hour);
  assign eq_date  = (al_date == cur_date);
  assign eq_month = (al_month == cur_month);

  always @* begin
    case (alarm_repeat_bits)
      `RPT_EVERY_MIN:   match = eq_sec;
      `RPT_EVERY_HOUR:  match = eq_sec & eq_min;
      `RPT_EVERY_DAY:   match = eq_sec & eq_min & eq_hour;
      `RPT_EVERY_MONTH: match = eq_sec & eq_min & eq_hour & eq_date;
      `RPT_EVERY_YEAR:  match = eq_sec & eq_min & eq_hour & eq_date & eq_month;
      // Undefined codes fire every second so a bad setting shows quickly
      default:          match = 1'b1;
    endcase
  end

endmodule // alarm_match

// >>> hw/rtc_aux.v
// RTC auxiliary logic: calibration, alarm, watchdog, square-wave and 32 kHz outputs
`timescale 1ns/1ps
`include "rtc_aux_regs.vh"

module rtc_aux #(
  parameter         HAS_WDO        = 0,
  parameter integer REC_PULSE_CYCLES = `REC_PULSE_CYC
) (
  // Clock and reset
  input  wire       SYS_CLK,
  input  wire       RST,
  // Oscillator from pin
  input  wire       OSC_IN,
  // Register port from serial interface
  input  wire       WR_STB,
  input  wire [3:0] WR_ADDR,
  input  wire [7:0] WR_DATA,
  input  wire       RD_STB,
  input  wire [3:0] RD_ADDR,
  output wire [7:0] RD_DATA,
  input  wire [3:0] PTR_ADDR,
  // Running time from calendar
  input  wire [4:0] CUR_MONTH,
  input  wire [5:0] CUR_DATE,
  input  wire [5:0] CUR_HOUR,
  input  wire [6:0] CUR_MIN,
  input  wire [6:0] CUR_SEC,
  // Time base to calendar
  output wire       SECOND_TICK,
  output wire       OSC_HALT,
  // Pins
  output wire       WAVE_PIN,
  output wire       FIXED_TONE_PIN,
  output wire       IRQ_N_O,
  output wire       IRQ_N_OE,
  output wire       WDO_N_O,
  output wire       WDO_N_OE
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  reg  [7:0]  trim_ff;
  reg  [7:0]  timeout_ff;
  reg  [7:0]  alarm_ff [0:`AL_REG_COUNT-1];
  reg  [3:0]  rate_sel_ff;
  reg         halt_ff;
  reg  [7:0]  rd_data_ff;
  reg         af_ff;
  reg         wdf_ff;
  reg         pend_ff;

  wire        wr_trim    = WR_STB && (WR_ADDR == `ADDR_RATE_TRIM);
  wire        wr_timeout = WR_STB && (WR_ADDR == `ADDR_TIMEOUT);
  wire        wr_clock   = WR_STB && (WR_ADDR <= `ADDR_CLOCK_LAST);
  wire        rd_flags   = RD_STB && (RD_ADDR == `ADDR_EVENT_FLAGS);
  wire [7:0]  flags_val  = {wdf_ff, af_ff, 6'h00};

  genvar gi;
  generate
    for (gi = 0; gi < `AL_REG_COUNT; gi = gi + 1) begin : g_alarm
      always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
          alarm_ff[gi] <= (gi == 0) ? `AL_MONTH_RST : `AL_OTHER_RST;
        end else if (WR_STB && (WR_ADDR == `ADDR_AL_MONTH + gi)) begin
          alarm_ff[gi] <= WR_DATA;
        end
      end
    end
  endgenerate

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      trim_ff     <= `RATE_TRIM_RST;
      timeout_ff  <= `TIMEOUT_RST;
      rate_sel_ff <= `RATE_SEL_RST;
      halt_ff     <= 1'b0;
    end else begin
      if (wr_trim) begin
        trim_ff <= WR_DATA;
      end
      if (wr_timeout) begin
        timeout_ff <= WR_DATA;
      end
      if (WR_STB && (WR_ADDR == `ADDR_DAY)) begin
        rate_sel_ff <= WR_DATA[`RATE_SEL_HI:`RATE_SEL_LO];
      end
      if (WR_STB && (WR_ADDR == `ADDR_SECONDS)) begin
        halt_ff <= WR_DATA[`HALT_BIT];
      end
    end
  end

  // Read data is sampled at the strobe so the clearing read still sees the flags
  reg [7:0] rd_mux;
  always @* begin
    case (RD_ADDR)
      `ADDR_RATE_TRIM:   rd_mux = trim_ff;
      `ADDR_TIMEOUT:     rd_mux = timeout_ff;
      `ADDR_AL_MONTH:    rd_mux = alarm_ff[0];
      `ADDR_AL_DATE:     rd_mux = alarm_ff[1];
      `ADDR_AL_HOUR:     rd_mux = alarm_ff[2];
      `ADDR_AL_MIN:      rd_mux = alarm_ff[3];
      `ADDR_AL_SEC:      rd_mux = alarm_ff[4];
      `ADDR_EVENT_FLAGS: rd_mux = flags_val;
      default:           rd_mux = 8'h00;
    endcase
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rd_data_ff <= 8'h00;
    end else if (RD_STB) begin
      rd_data_ff <= rd_mux;
    end
  end

  // ****************************************************************
  // Oscillator sampling and dividers
  // ****************************************************************
  reg         osc_s1_ff;
  reg         osc_s2_ff;
  reg         osc_d_ff;
  reg  [14:0] wave_div_ff;
  reg  [15:0] sec_div_ff;
  reg  [5:0]  sec_in_min_ff;
  reg  [5:0]  cal_min_ff;
  reg         sec_pulse_ff;
  reg         check_ff;

  wire        run_tick = osc_s2_ff & ~osc_d_ff & ~halt_ff;
  wire [5:0]  cal_span = {trim_ff[`TRIM_MAG_HI:0], 1'b0};
  wire        cal_now  = (sec_in_min_ff == 6'h00) && (cal_min_ff < cal_span) &&
                         (cal_min_ff < `CAL_ELIGIBLE_MIN);
  // Positive trim speeds up by shortening; negative slows by lengthening
  wire [15:0] sec_len  = !cal_now ? `OSC_PER_SEC :
                         trim_ff[`TRIM_SIGN_BIT] ? (`OSC_PER_SEC - `CAL_SHORTEN) :
                                                   (`OSC_PER_SEC + `CAL_LENGTHEN);
  wire        sec_end  = run_tick && (sec_div_ff == sec_len - 16'h0001);

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      osc_s1_ff     <= 1'b0;
      osc_s2_ff     <= 1'b0;
      osc_d_ff      <= 1'b0;
      wave_div_ff   <= 15'h0000;
      sec_div_ff    <= 16'h0000;
      sec_in_min_ff <= 6'h00;
      cal_min_ff    <= 6'h00;
      sec_pulse_ff  <= 1'b0;
      check_ff      <= 1'b0;
    end else begin
      osc_s1_ff    <= OSC_IN;
      osc_s2_ff    <= osc_s1_ff;
      osc_d_ff     <= osc_s2_ff;
      sec_pulse_ff <= sec_end;
      check_ff     <= sec_pulse_ff;
      // Free divider kept apart from the trimmed one
      if (run_tick) begin
        wave_div_ff <= wave_div_ff + 15'h0001;
      end
      if (sec_end) begin
        sec_div_ff <= 16'h0000;
        if (sec_in_min_ff == `SEC_PER_MIN - 6'h01) begin
          sec_in_min_ff <= 6'h00;
          cal_min_ff    <= cal_min_ff + 6'h01;
        end else begin
          sec_in_min_ff <= sec_in_min_ff + 6'h01;
        end
      end else if (run_tick) begin
        sec_div_ff <= sec_div_ff + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Alarm
  // ****************************************************************
  wire        al_match;
  wire [4:0]  rpt = {alarm_ff[1][`REPEAT5_BIT], alarm_ff[1][`REPEAT_BIT],
                     alarm_ff[2][`REPEAT_BIT], alarm_ff[3][`REPEAT_BIT],
                     alarm_ff[4][`REPEAT_BIT]};

  alarm_match u_match (
    .alarm_repeat_bits (rpt),
    .al_month          (alarm_ff[0][4:0]),
    .al_date           (alarm_ff[1][5:0]),
    .al_hour           (alarm_ff[2][5:0]),
    .al_min            (alarm_ff[3][6:0]),
    .al_sec            (alarm_ff[4][6:0]),
    .cur_month         (CUR_MONTH),
    .cur_date          (CUR_DATE),
    .cur_hour          (CUR_HOUR),
    .cur_min           (CUR_MIN),
    .cur_sec           (CUR_SEC),
    .match             (al_match)
  );

  // Compare a cycle after the tick, once the calendar has stepped
  wire        hit      = check_ff & al_match;
  wire        ptr_on_f = (PTR_ADDR == `ADDR_EVENT_FLAGS);
  wire        af_set   = ~ptr_on_f & (hit | pend_ff);

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      af_ff   <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= ptr_on_f & (pend_ff | hit);
      // Set wins over the clearing read
      af_ff   <= af_set | (af_ff & ~rd_flags);
    end
  end

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  reg         wd_en_ff;
  reg  [14:0] wd_cnt_ff;
  reg  [10:0] wd_phase_ff;
  reg         wd_irq_ff;
  reg  [31:0] rec_cnt_ff;
  reg  [9:0]  wd_unit;

  wire [2:0]  cur_res  = {timeout_ff[`WD_RES_HI_BIT], timeout_ff[`WD_RES_LO_HI:0]};
  wire [4:0]  cur_mult = timeout_ff[`WD_MULT_HI:`WD_MULT_LO];
  wire [2:0]  new_res  = {WR_DATA[`WD_RES_HI_BIT], WR_DATA[`WD_RES_LO_HI:0]};
  wire [4:0]  new_mult = WR_DATA[`WD_MULT_HI:`WD_MULT_LO];
  wire [2:0]  sel_res  = wr_timeout ? new_res : cur_res;
  wire [4:0]  sel_mult = wr_timeout ? new_mult : cur_mult;
  wire [14:0] wd_load  = {10'h000, sel_mult} * {5'h00, wd_unit};
  wire        restart  = wr_timeout | (wr_clock & wd_en_ff);
  wire        tick16   = run_tick && (wd_phase_ff == `WD_TICK_OSC);
  wire        expire   = wd_en_ff && (wd_cnt_ff == 15'h0000) && !restart;

  always @* begin
    case (sel_res)
      3'h0:    wd_unit = `WD_UNIT_16TH;
      3'h1:    wd_unit = `WD_UNIT_QUARTER;
      3'h2:    wd_unit = `WD_UNIT_SEC;
      3'h3:    wd_unit = `WD_UNIT_4SEC;
      3'h4:    wd_unit = `WD_UNIT_MIN;
      default: wd_unit = 10'h000;
    endcase
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wd_en_ff    <= 1'b0;
      wd_cnt_ff   <= 15'h0000;
      wd_phase_ff <= 11'h000;
      wd_irq_ff   <= 1'b0;
      wdf_ff      <= 1'b0;
      rec_cnt_ff  <= 32'h0000_0000;
    end else begin
      if (restart) begin
        wd_cnt_ff   <= wd_load;
        wd_phase_ff <= 11'h000;
        if (wr_timeout) begin
          // Zero value, or invalid resolution, leaves it idle
          wd_en_ff <= (WR_DATA != 8'h00) && (new_res <= `WD_RES_MAX);
        end
      end else begin
        if (run_tick) begin
          wd_phase_ff <= wd_phase_ff + 11'h001;
        end
        if (tick16 && (wd_cnt_ff != 15'h0000)) begin
          wd_cnt_ff <= wd_cnt_ff - 15'h0001;
        end
        // A zero load expires on the next cycle
        if (expire) begin
          wd_en_ff <= 1'b0;
        end
      end
      wdf_ff <= expire | (wdf_ff & ~rd_flags);
      if (HAS_WDO == 0) begin
        wd_irq_ff <= (expire & ~halt_ff) | (wd_irq_ff & ~wr_timeout) | expire;
      end
      if ((HAS_WDO != 0) && expire && !halt_ff) begin
        rec_cnt_ff <= REC_PULSE_CYCLES;
      end else if (rec_cnt_ff != 32'h0000_0000) begin
        rec_cnt_ff <= rec_cnt_ff - 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  reg         wave_ff;
  reg         tone_ff;
  reg         irq_oe_ff;
  reg         wave_sel;

  wire        irq_active = (af_ff & alarm_ff[0][`AFE_BIT]) | wd_irq_ff;
  wire        ft_mode    = trim_ff[`TRIM_FT_BIT] & trim_ff[`TRIM_OUT_BIT] & ~halt_ff;

  always @* begin
    case (rate_sel_ff)
      4'h0:    wave_sel = 1'b0;
      4'h1:    wave_sel = osc_s2_ff;
      default: wave_sel = wave_div_ff[rate_sel_ff - 4'h1];
    endcase
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wave_ff   <= 1'b0;
      tone_ff   <= 1'b0;
      irq_oe_ff <= 1'b0;
    end else begin
      wave_ff   <= wave_sel & alarm_ff[0][`WAVE_PIN_ENABLE_BIT] & ~halt_ff;
      tone_ff   <= osc_s2_ff & alarm_ff[0][`TONE_EN_BIT] & ~halt_ff;
      // Open drain: interrupt first, then the 512 Hz test tone, else the output level
      irq_oe_ff <= irq_active |
                   (ft_mode ? ~wave_div_ff[`WAVE_512_BIT] : ~trim_ff[`TRIM_OUT_BIT]);
    end
  end

  assign RD_DATA        = rd_data_ff;
  assign SECOND_TICK    = sec_pulse_ff;
  assign OSC_HALT       = halt_ff;
  assign WAVE_PIN       = wave_ff;
  assign FIXED_TONE_PIN = tone_ff;
  assign IRQ_N_O        = 1'b0;
  assign IRQ_N_OE       = irq_oe_ff;
  assign WDO_N_O        = 1'b0;
  assign WDO_N_OE       = (rec_cnt_ff != 32'h0000_0000);

endmodule // rtc_aux

// >>> sim/rtc_aux_props.sv
// Concurrent checks on the ports of the RTC auxiliary block
`timescale 1ns/1ps

module rtc_aux_props #(
  parameter         HAS_WDO          = 0,
  parameter integer REC_PULSE_CYCLES = 20
) (
  // Clock and reset
  input wire       SYS_CLK,
  input wire       RST,
  // Register port
  input wire       WR_STB,
  input wire [3:0] WR_ADDR,
  input wire [7:0] WR_DATA,
  input wire       RD_STB,
  input wire [3:0] RD_ADDR,
  input wire [7:0] RD_DATA,
  // Pins
  input wire       OSC_HALT,
  input wire       WAVE_PIN,
  input wire       FIXED_TONE_PIN,
  input wire       IRQ_N_OE,
  input wire       WDO_N_OE
);
  // ****************************************
  // Mirrored gating bits, pulse length
  // ****************************************
  logic        wave_en_ff;
  logic        rate_on_ff;
  logic        tone_en_ff;
  logic [31:0] pulse_len_ff;
  wire         wd_wr  = WR_STB && WR_ADDR == 4'h9;
  wire  [2:0]  wr_res = {WR_DATA[7], WR_DATA[1:0]};

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wave_en_ff   <= 1'b1;
      rate_on_ff   <= 1'b1;
      tone_en_ff   <= 1'b1;
      pulse_len_ff <= 32'h0;
    end else begin
      if (WR_STB && WR_ADDR == 4'ha) begin
        wave_en_ff <= WR_DATA[6];
        tone_en_ff <= WR_DATA[5];
      end
      if (WR_STB && WR_ADDR == 4'h4) begin
        rate_on_ff <= WR_DATA[7:4] != 4'h0;
      end
      pulse_len_ff <= WDO_N_OE ? pulse_len_ff + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_trim_readback: assert property (
    (WR_STB && WR_ADDR == 4'h8) ##2 (RD_STB && RD_ADDR == 4'h8)
    |=> RD_DATA == $past(WR_DATA, 3)) else $error("trim read back differs");
  a_flag_read_clr: assert property (
    (RD_STB && RD_ADDR == 4'hf) ##2 (RD_STB && RD_ADDR == 4'hf) |=> !RD_DATA[7])
    else $error("watchdog flag survived a flags read");
  a_zero_mult_fire: assert property (
    wd_wr && WR_DATA[6:2] == 5'h00 && wr_res inside {[3'h1:3'h4]}
    |-> ##[1:3] ((HAS_WDO != 0) ? WDO_N_OE : IRQ_N_OE)) else $error("no immediate time-out");
  a_bad_res_quiet: assert property (
    wd_wr && wr_res > 3'h4 |=> (!$rose(WDO_N_OE))[*8]) else $error("invalid code timed out");
  a_pulse_len: assert property (
    pulse_len_ff != 32'h0 && $fell(WDO_N_OE) |-> pulse_len_ff == REC_PULSE_CYCLES)
    else $error("reset pulse length wrong");
  a_wave_gated: assert property (
    (!(wave_en_ff && rate_on_ff))[*4] |-> $stable(WAVE_PIN)) else $error("wave pin not gated");
  a_halt_wave: assert property (
    OSC_HALT[*4] |-> $stable(WAVE_PIN)) else $error("wave pin runs while halted");
  a_tone_gated: assert property (
    (!tone_en_ff || OSC_HALT)[*4] |-> $stable(FIXED_TONE_PIN)) else $error("tone pin not gated");

  c_immediate: cover property (wd_wr && WR_DATA[6:2] == 5'h00);
  c_wdo_pulse: cover property ($rose(WDO_N_OE));
  c_irq_rise: cover property ($rose(IRQ_N_OE));
endmodule // rtc_aux_props

bind rtc_aux rtc_aux_props #(.HAS_WDO(HAS_WDO), .REC_PULSE_CYCLES(REC_PULSE_CYCLES))
  rtc_aux_props_i (.SYS_CLK(SYS_CLK), .RST(RST), .WR_STB(WR_STB), .WR_ADDR(WR_ADDR),
  .WR_DATA(WR_DATA), .RD_STB(RD_STB), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
  .OSC_HALT(OSC_HALT), .WAVE_PIN(WAVE_PIN), .FIXED_TONE_PIN(FIXED_TONE_PIN),
  .IRQ_N_OE(IRQ_N_OE), .WDO_N_OE(WDO_N_OE));

// >>> sim/host_model.sv
// Host processor and crystal model facing the register port
`timescale 1ns/1ps

module host_model (
  // Clock
  input  wire        sys_clk,
  // Crystal
  output logic       osc_in,
  // Register port
  output logic       wr_stb,
  output logic [3:0] wr_addr,
  output logic [7:0] wr_data,
  output logic       rd_stb,
  output logic [3:0] rd_addr,
  input  wire  [7:0] rd_data,
  output logic [3:0] ptr_addr
);
  initial begin
    osc_in   = 1'b0;
    wr_stb   = 1'b0;
    wr_addr  = 4'h0;
    wr_data  = 8'h00;
    rd_stb   = 1'b0;
    rd_addr  = 4'h0;
    ptr_addr = 4'h0;
  end

  // Crystal half period in system cycles; four-cycle period keeps the run short
  int osc_half = 2;

  always begin
    repeat (osc_half) @(negedge sys_clk);
    osc_in <= ~osc_in;
  end

  // Pointer steps past each byte, as the serial interface does
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    wr_stb  = 1'b1;
    wr_addr = a;
    wr_data = v;
    @(negedge sys_clk);
    wr_stb   = 1'b0;
    ptr_addr = a + 4'h1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    rd_stb  = 1'b1;
    rd_addr = a;
    @(negedge sys_clk);
    v        = rd_data;
    rd_stb   = 1'b0;
    ptr_addr = a + 4'h1;
  endtask
endmodule // host_model

// >>> sim/tb_top.sv
// Self-checking testbench for both output variants of the RTC auxiliary block
`timescale 1ns/1ps

`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); \
  end \
end

module tb_top;
  // ****************************************
  // Wiring
  // ****************************************
  logic       sys_clk;
  logic       rst;
  wire        osc_in, wr_stb, rd_stb;
  wire  [3:0] wr_addr, rd_addr, ptr_addr;
  wire  [7:0] wr_data, rd_data;
  wire        halt0, wave0, tone0, irq0_oe, wdo1_oe;
  wire        sec_tick;
  logic [4:0] cur_month = 5'h01;
  logic [5:0] cur_date = 6'h01;
  logic [5:0] cur_hour = 6'h00;
  logic [6:0] cur_min = 7'h00;
  logic [6:0] cur_sec = 7'h00;
  int         errors = 0;
  int         comparisons = 0;
  int         wdo_rises = 0;
  logic       wdo_q = 1'b0;
  logic [7:0] d;
  int         n;
  int         r0;

  host_model host (.sys_clk(sys_clk), .osc_in(osc_in), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data),
    .ptr_addr(ptr_addr));
  rtc_aux #(.HAS_WDO(0), .REC_PULSE_CYCLES(20)) rtc_aux_i (.SYS_CLK(sys_clk), .RST(rst),
    .OSC_IN(osc_in), .WR_STB(wr_stb), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_STB(rd_stb),
    .RD_ADDR(rd_addr), .RD_DATA(rd_data), .PTR_ADDR(ptr_addr), .CUR_MONTH(cur_month),
    .CUR_DATE(cur_date), .CUR_HOUR(cur_hour), .CUR_MIN(cur_min), .CUR_SEC(cur_sec),
    .SECOND_TICK(sec_tick),
    .OSC_HALT(halt0), .WAVE_PIN(wave0), .FIXED_TONE_PIN(tone0), .IRQ_N_O(),
    .IRQ_N_OE(irq0_oe), .WDO_N_O(), .WDO_N_OE());
  rtc_aux #(.HAS_WDO(1), .REC_PULSE_CYCLES(20)) rtc_aux_wdo_i (.SYS_CLK(sys_clk), .RST(rst),
    .OSC_IN(osc_in), .WR_STB(wr_stb), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_STB(rd_stb),
    .RD_ADDR(rd_addr), .RD_DATA(), .PTR_ADDR(ptr_addr), .CUR_MONTH(cur_month),
    .CUR_DATE(cur_date), .CUR_HOUR(cur_hour), .CUR_MIN(cur_min), .CUR_SEC(cur_sec),
    .SECOND_TICK(),
    .OSC_HALT(), .WAVE_PIN(), .FIXED_TONE_PIN(), .IRQ_N_O(), .IRQ_N_OE(), .WDO_N_O(),
    .WDO_N_OE(wdo1_oe));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (wdo1_oe === 1'b1 && wdo_q !== 1'b1) wdo_rises++;
    wdo_q <= wdo1_oe;
  end

  function automatic logic pick(input int w);
    case (w)
      0: pick = wave0;
      1: pick = irq0_oe;
      default: pick = tone0;
    endcase
  endfunction

  // Half period in cycles, zero when the pin holds still
  task automatic half(input int w, output int h);
    logic s;
    int i;
    h = 0;
    i = 0;
    @(negedge sys_clk);
    s = pick(w);
    while (pick(w) === s && i < 2100) begin
      @(negedge sys_clk);
      i++;
    end
    if (i == 2100) return;
    s = pick(w);
    while (pick(w) === s && h < 2100) begin
      @(negedge sys_clk);
      h++;
    end
  endtask

  task automatic wait_irq(input int lim);
    n = 0;
    while (irq0_oe !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == lim) begin
      errors++;
      $display("MISMATCH t=%0t interrupt never came", $time);
      close_out;
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic regs_and_tones;
    int k;
    host.rd(4'h9, d);
    `CHK(d, 8'h00)
    host.rd(4'hf, d);
    `CHK(d, 8'h00)
    host.wr(4'h8, 8'h25);
    host.rd(4'h8, d);
    `CHK(d, 8'h25)
    for (k = 0; k < 10; k++) begin
      host.wr(4'h4, 8'(k << 4));
      half(0, n);
      `CHK(n, k == 0 ? 0 : k == 1 ? 2 : 2 << k)
    end
    host.wr(4'h4, 8'h60);
    half(0, n);
    `CHK(n, 128)
    host.wr(4'h8, 8'hc0);
    half(1, n);
    `CHK(n, 128)
    host.wr(4'h8, 8'h80);
    host.wr(4'ha, 8'h20);
    half(0, n);
    `CHK(n, 0)
    half(2, n);
    `CHK(n, 2)
    host.wr(4'h1, 8'h80);
    `CHK(halt0, 1'b1)
    half(2, n);
    `CHK(n, 0)
    host.wr(4'ha, 8'h40);
    host.wr(4'h1, 8'h00);
    half(0, n);
    `CHK(n, 128)
    half(2, n);
    `CHK(n, 0)
    host.wr(4'ha, 8'h60);
    $display("registers and tones done");
  endtask

  task automatic watchdog;
    r0 = wdo_rises;
    host.wr(4'h9, 8'h04);
    wait_irq(9000);
    `CHK(n >= 8184 && n <= 8204, 1'b1)
    repeat (30) @(negedge sys_clk);
    `CHK(wdo_rises, r0 + 1)
    host.rd(4'hf, d);
    `CHK(d[7], 1'b1)
    host.rd(4'hf, d);
    `CHK(d[7], 1'b0)
    `CHK(irq0_oe, 1'b1)
    host.wr(4'h9, 8'h00);
    repeat (3) @(negedge sys_clk);
    `CHK(irq0_oe, 1'b0)
    host.wr(4'h9, 8'h01);
    repeat (3) @(negedge sys_clk);
    `CHK(irq0_oe, 1'b1)
    repeat (25) @(negedge sys_clk);
    `CHK(wdo_rises, r0 + 2)
    host.wr(4'h9, 8'h04);
    repeat (6000) @(negedge sys_clk);
    host.wr(4'h2, 8'h00);
    repeat (6000) @(negedge sys_clk);
    `CHK(irq0_oe, 1'b0)
    wait_irq(3000);
    `CHK(n > 2000, 1'b1)
    repeat (30) @(negedge sys_clk);
    host.wr(4'h9, 8'h87);
    repeat (9000) @(negedge sys_clk);
    `CHK(irq0_oe, 1'b0)
    `CHK(wdo_rises, r0 + 3)
    $display("watchdog done");
  endtask

  // One second only fits the run with the crystal at full speed
  task automatic alarm;
    int i;
    host.wr(4'ha, 8'he0);
    host.wr(4'hb, 8'hc0);
    host.wr(4'hc, 8'h80);
    host.wr(4'hd, 8'h80);
    // Every minute at second 25; last byte leaves the pointer on the flags
    host.wr(4'he, 8'h25);
    cur_sec  = 7'h25;
    cur_min  = 7'h07;
    cur_hour = 6'h13;
    host.osc_half = 1;
    i = 0;
    while (sec_tick !== 1'b1 && i < 60000) begin
      @(negedge sys_clk);
      i++;
    end
    if (i == 60000) begin
      errors++;
      $display("MISMATCH t=%0t second tick never came", $time);
      close_out;
    end
    repeat (5) @(negedge sys_clk);
    `CHK(irq0_oe, 1'b0)
    host.rd(4'hf, d);
    `CHK(d[6], 1'b0)
    repeat (3) @(negedge sys_clk);
    `CHK(irq0_oe, 1'b1)
    host.rd(4'hf, d);
    `CHK(d[6], 1'b1)
    repeat (2) @(negedge sys_clk);
    `CHK(irq0_oe, 1'b0)
    host.rd(4'hf, d);
    `CHK(d[6], 1'b0)
    host.wr(4'hb, 8'h00);
    host.wr(4'hc, 8'h00);
    host.wr(4'hd, 8'h00);
    host.wr(4'he, 8'h00);
    $display("alarm done");
  endtask

  initial begin
    rst = 1'b1;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    regs_and_tones;
    watchdog;
    alarm;
    close_out;
  end
endmodule // tb_top
